// ---- testbench/qdx_decoder_tb.sv ----
// qdx_decoder_tb: random and corner-case checks of the quadrature decoder extension
// assumes the encoder model drives all eight port pins
`timescale 1ns/1ps
module qdx_decoder_tb;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic stp = 1'b0;
  logic dir = 1'b0;
  logic [1:0] pair = 2'h0;
  logic [7:0] pins;
  logic [7:0] o_rdata;
  logic o_irq;
  logic [1:0] o_irq_prio;
  logic [9:0] cnt [2] = '{10'h000, 10'h000};
  logic [7:0] tbl [4] = '{8'h82, 8'h0F, 8'hE8, 8'hAD};
  logic [7:0] ctl = 8'h00;
  logic [1:0] st = 2'h0;
  logic [1:0] msk = 2'h0;
  logic [15:0] lfsr = 16'h0EEE;
  int errors = 0;
  int tests_run = 0;

  always #25 i_ref_clk = ~i_ref_clk;

  qdx_encoder_model u_enc (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_step(stp), .i_up(dir),
    .i_pair(pair), .o_pins(pins));
  qdx_decoder u_dut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_port_pins(pins), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_irq_prio(o_irq_prio));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // pair p moves decoder d when its select names that pair
  function automatic logic feeds(input int d, input logic [1:0] p);
    logic [1:0] s;
    s = d == 0 ? ctl[3:2] : ctl[7:6];
    return (s == 2'h2 && p == 2'(d)) || (s == 2'h3 && p == 2'(d + 2));
  endfunction
  function automatic logic irq_exp();
    return (|(st & msk)) && ctl[1:0] != 2'h0;
  endfunction

  task automatic chk(input string name, input logic [9:0] e, input logic [9:0] got);
    tests_run++;
    if (got !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    if (a == 8'h91) ctl = d;
    if (a == 8'h98) st = st & ~d[1:0];
    if (a == 8'h99) msk = d[1:0];
    @(posedge i_ref_clk);
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(name, {2'h0, e}, {2'h0, o_rdata});
    @(posedge i_ref_clk);
  endtask
  task automatic rd_cnt(input int d);
    rd("count low", 8'h94 + 8'(2*d), cnt[d][7:0]);
    rd("count high", 8'h95 + 8'(2*d), {6'h00, cnt[d][9:8]});
  endtask
  task automatic chk_irq();
    #1 chk("irq", {9'h000, irq_exp()}, {9'h000, o_irq});
    @(posedge i_ref_clk);
  endtask
  // expectation moves first, then the encoder takes one step; three idle clocks let the count land
  task automatic step(input logic [1:0] p, input logic up);
    logic [9:0] m;
    m = ctl[5] ? 10'h3FF : 10'h0FF;
    for (int d = 0; d < 2; d++) begin
      if (feeds(d, p)) begin
        if (up ? cnt[d] == m : cnt[d] == 10'h000) st[d] = 1'b1;
        cnt[d] = (up ? cnt[d] + 10'h001 : cnt[d] - 10'h001) & m;
      end
    end
    pair <= p;
    dir <= up;
    stp <= 1'b1;
    @(posedge i_ref_clk);
    stp <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    @(posedge i_ref_clk);
    rd("control reset", 8'h91, 8'h00);
    rd("unmapped", 8'h80, 8'h00);
    // narrow entries come first so bits 9:8 are already zero when widening
    foreach (tbl[i]) begin
      wr(8'h91, tbl[i]);
      rd("control", 8'h91, tbl[i]);
      chk("prio", {8'h00, ctl[1:0]}, {8'h00, o_irq_prio});
      rd_cnt(0);
      rd_cnt(1);
      repeat (60) begin
        lfsr = lfsr_next(lfsr);
        step(lfsr[1:0], lfsr[2]);
      end
      rd_cnt(0);
      rd_cnt(1);
      rd("status", 8'h98, {6'h00, st});
      chk_irq();
    end
    wr(8'h98, 8'h03);
    wr(8'h99, 8'h01);
    rd("mask", 8'h99, {6'h00, msk});
    rd("status cleared", 8'h98, 8'h00);
    chk_irq();
    while (cnt[0] != 10'h000) step(2'h2, 1'b0);
    rd("count low", 8'h94, 8'h00);
    step(2'h2, 1'b0);
    rd("high latched", 8'h95, 8'h00);
    rd("high live", 8'h95, 8'h03);
    step(2'h2, 1'b1);
    rd("count low", 8'h94, cnt[0][7:0]);
    rd("status", 8'h98, {6'h00, st});
    chk_irq();
    wr(8'h91, 8'hAC);
    chk_irq();
    wr(8'h91, 8'hAD);
    wr(8'h99, 8'h00);
    chk_irq();
    wr(8'h99, 8'h01);
    chk_irq();
    wr(8'h98, 8'h01);
    chk_irq();
    end_sim();
  end

  initial begin
    repeat (50000) @(posedge i_ref_clk);
    errors++;
    end_sim();
  end
endmodule // qdx_decoder_tb

// ---- testbench/qdx_encoder_model.sv ----
// qdx_encoder_model: incremental encoders on four port pin pairs, one gray step per request
// assumes requests at least one clock apart, pins sampled on the same clock
`timescale 1ns/1ps
module qdx_encoder_model (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_step,
  input wire logic i_up,
  input wire logic [1:0] i_pair,
  output logic [7:0] o_pins
);
  logic [1:0] ab;
  assign ab = o_pins[2*i_pair +: 2];
  // one gray step per request: a real encoder never skips a state
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pins <= 8'h00;
    end else if (i_step) begin
      o_pins[2*i_pair +: 2] <= i_up ? {ab[0], ~ab[1]} : {~ab[0], ab[1]};
    end
  end
endmodule // qdx_encoder_model

// ---- verilog/qdx_decoder.sv ----
// qdx_decoder: two quadrature decoders with 8/10-bit counters, high-bit latch and register port
// assumes port pins are synchronous to i_ref_clk and a one-cycle read/write strobe master
`timescale 1ns/1ps

module qdx_decoder (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [qdx_pkg::PORT_W-1:0] i_port_pins,
  input wire logic [qdx_pkg::ADDR_W-1:0] i_addr,
  input wire logic [qdx_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [qdx_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq,
  output logic [1:0] o_irq_prio
);

  typedef enum logic [1:0] {QDX_HOLD, QDX_UP, QDX_DOWN} qdx_step_e;

  logic [qdx_pkg::DATA_W-1:0] control_reg;
  logic [qdx_pkg::CNT_W-1:0] count_one_reg;
  logic [qdx_pkg::CNT_W-1:0] count_two_reg;
  logic [1:0] phase_one_reg;
  logic [1:0] phase_two_reg;
  logic [1:0] sel_one_prev_reg;
  logic [1:0] sel_two_prev_reg;
  logic held_one_reg;
  logic held_two_reg;
  logic [qdx_pkg::HI_W-1:0] latch_one_reg;
  logic [qdx_pkg::HI_W-1:0] latch_two_reg;
  logic [qdx_pkg::IRQ_W-1:0] status_reg;
  logic [qdx_pkg::IRQ_W-1:0] mask_reg;
  logic [qdx_pkg::DATA_W-1:0] rdata_next;
  logic [1:0] sel_one;
  logic [1:0] sel_two;
  logic [1:0] phase_one;
  logic [1:0] phase_two;
  logic wide;
  qdx_step_e step_one;
  qdx_step_e step_two;
  logic [qdx_pkg::CNT_W-1:0] count_one_next;
  logic [qdx_pkg::CNT_W-1:0] count_two_next;
  logic wrap_one;
  logic wrap_two;
  logic [qdx_pkg::IRQ_W-1:0] wrap_events;

  // pick the phase pair for a decoder; disabled or reserved codes give a steady zero pair
  function automatic logic [1:0] pick_pins(input logic [1:0] sel, input logic [1:0] low_pair,
                                           input logic [1:0] high_pair);
    logic [1:0] pair;
    pair = 2'h0;
    case (sel)
      qdx_pkg::SEL_LOW_PINS: pair = low_pair;
      qdx_pkg::SEL_HIGH_PINS: pair = high_pair;
      default: pair = 2'h0;
    endcase
    return pair;
  endfunction

  // gray-code direction; a double jump is invalid and ignored
  function automatic qdx_step_e decode_step(input logic [1:0] prev, input logic [1:0] cur);
    qdx_step_e st;
    st = QDX_HOLD;
    case ({prev, cur})
      4'h1, 4'h7, 4'hE, 4'h8: st = QDX_UP;
      4'h2, 4'hB, 4'hD, 4'h4: st = QDX_DOWN;
      default: st = QDX_HOLD;
    endcase
    return st;
  endfunction

  // advance a counter and wrap it at the selected width
  function automatic logic [qdx_pkg::CNT_W:0] advance(input logic [qdx_pkg::CNT_W-1:0] cnt,
                                                     input qdx_step_e st, input logic wide_mode);
    logic [qdx_pkg::CNT_W-1:0] nxt;
    logic wrapped;
    nxt = cnt;
    wrapped = 1'b0;
    case (st)
      QDX_UP: begin
        nxt = cnt + 10'h001;
        wrapped = wide_mode ? (cnt == 10'h3FF) : (cnt[qdx_pkg::CNT_LO_W-1:0] == 8'hFF);
      end
      QDX_DOWN: begin
        nxt = cnt - 10'h001;
        wrapped = wide_mode ? (cnt == 10'h000) : (cnt[qdx_pkg::CNT_LO_W-1:0] == 8'h00);
      end
      default: nxt = cnt;
    endcase
    if (!wide_mode) begin
      nxt[qdx_pkg::CNT_W-1:qdx_pkg::CNT_LO_W] = 2'h0;
    end
    return {wrapped, nxt};
  endfunction

  assign sel_one = control_reg[qdx_pkg::CTL_SEL_ONE_HI:qdx_pkg::CTL_SEL_ONE_LO];
  assign sel_two = control_reg[qdx_pkg::CTL_SEL_TWO_HI:qdx_pkg::CTL_SEL_TWO_LO];
  assign wide = control_reg[qdx_pkg::CTL_WIDE_BIT];

  assign phase_one = pick_pins(sel_one,
    {i_port_pins[qdx_pkg::PIN_ONE_LOW_A], i_port_pins[qdx_pkg::PIN_ONE_LOW_B]},
    {i_port_pins[qdx_pkg::PIN_ONE_HIGH_A], i_port_pins[qdx_pkg::PIN_ONE_HIGH_B]});
  assign phase_two = pick_pins(sel_two,
    {i_port_pins[qdx_pkg::PIN_TWO_LOW_A], i_port_pins[qdx_pkg::PIN_TWO_LOW_B]},
    {i_port_pins[qdx_pkg::PIN_TWO_HIGH_A], i_port_pins[qdx_pkg::PIN_TWO_HIGH_B]});

  // a select change re-seeds the phase history, so the pin swap is not seen as motion
  assign step_one = (sel_one != sel_one_prev_reg) ? QDX_HOLD : decode_step(phase_one_reg, phase_one);
  assign step_two = (sel_two != sel_two_prev_reg) ? QDX_HOLD : decode_step(phase_two_reg, phase_two);
  assign {wrap_one, count_one_next} = advance(count_one_reg, step_one, wide);
  assign {wrap_two, count_two_next} = advance(count_two_reg, step_two, wide);

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_reg <= qdx_pkg::CTL_RESET;
    end else if (i_wr && i_addr == qdx_pkg::ADDR_CONTROL) begin
      control_reg <= i_wdata;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_one_reg <= 2'h0;
      phase_two_reg <= 2'h0;
      sel_one_prev_reg <= qdx_pkg::SEL_OFF;
      sel_two_prev_reg <= qdx_pkg::SEL_OFF;
      count_one_reg <= qdx_pkg::CNT_RESET;
      count_two_reg <= qdx_pkg::CNT_RESET;
    end else begin
      phase_one_reg <= phase_one;
      phase_two_reg <= phase_two;
      sel_one_prev_reg <= sel_one;
      sel_two_prev_reg <= sel_two;
      count_one_reg <= count_one_next;
      count_two_reg <= count_two_next;
    end
  end

  // high-bit holding latches
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      held_one_reg <= 1'b0;
      held_two_reg <= 1'b0;
      latch_one_reg <= 2'h0;
      latch_two_reg <= 2'h0;
    end else if (i_rd) begin
      if (i_addr == qdx_pkg::ADDR_ONE_LOW) begin
        held_one_reg <= 1'b1;
        latch_one_reg <= count_one_reg[qdx_pkg::CNT_W-1:qdx_pkg::CNT_LO_W];
      end
      if (i_addr == qdx_pkg::ADDR_ONE_HIGH) begin
        held_one_reg <= 1'b0;
      end
      if (i_addr == qdx_pkg::ADDR_TWO_LOW) begin
        held_two_reg <= 1'b1;
        latch_two_reg <= count_two_reg[qdx_pkg::CNT_W-1:qdx_pkg::CNT_LO_W];
      end
      if (i_addr == qdx_pkg::ADDR_TWO_HIGH) begin
        held_two_reg <= 1'b0;
      end
    end
  end

  assign wrap_events = {wrap_two, wrap_one};

  // sticky status: set wins over a write-one clear in the same cycle
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (i_wr && i_addr == qdx_pkg::ADDR_IRQ_MASK) begin
        mask_reg <= i_wdata[qdx_pkg::IRQ_W-1:0];
      end
      if (i_wr && i_addr == qdx_pkg::ADDR_IRQ_STATUS) begin
        status_reg <= (status_reg & ~i_wdata[qdx_pkg::IRQ_W-1:0]) | wrap_events;
      end else begin
        status_reg <= status_reg | wrap_events;
      end
    end
  end

  // priority 00 keeps the line quiet whatever the status holds
  assign o_irq = (|(status_reg & mask_reg)) &&
                 (control_reg[qdx_pkg::CTL_PRIO_HI:qdx_pkg::CTL_PRIO_LO] != qdx_pkg::PRIO_OFF);
  assign o_irq_prio = control_reg[qdx_pkg::CTL_PRIO_HI:qdx_pkg::CTL_PRIO_LO];

  always_comb begin
    rdata_next = '0;
    case (i_addr)
      qdx_pkg::ADDR_CONTROL: rdata_next = control_reg;
      qdx_pkg::ADDR_ONE_LOW: rdata_next = count_one_reg[qdx_pkg::CNT_LO_W-1:0];
      qdx_pkg::ADDR_TWO_LOW: rdata_next = count_two_reg[qdx_pkg::CNT_LO_W-1:0];
      qdx_pkg::ADDR_ONE_HIGH: rdata_next = {6'h00, held_one_reg ? latch_one_reg :
                                            count_one_reg[qdx_pkg::CNT_W-1:qdx_pkg::CNT_LO_W]};
      qdx_pkg::ADDR_TWO_HIGH: rdata_next = {6'h00, held_two_reg ? latch_two_reg :
                                            count_two_reg[qdx_pkg::CNT_W-1:qdx_pkg::CNT_LO_W]};
      qdx_pkg::ADDR_IRQ_STATUS: rdata_next = {6'h00, status_reg};
      qdx_pkg::ADDR_IRQ_MASK: rdata_next = {6'h00, mask_reg};
      default: rdata_next = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? rdata_next : '0;
    end
  end

  property p_narrow_top_zero;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !wide |=> count_one_reg[9:8] == 2'h0 && count_two_reg[9:8] == 2'h0;
  endproperty
  a_narrow_top_zero: assert property (p_narrow_top_zero) else $error("upper bits set in 8-bit mode");

  property p_wide_carry;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    wide && step_one == QDX_UP && count_one_reg == 10'h0FF |=> count_one_reg == 10'h100;
  endproperty
  a_wide_carry: assert property (p_wide_carry) else $error("10-bit carry missing");

  sequence s_low_read_one;
    i_rd && i_addr == qdx_pkg::ADDR_ONE_LOW;
  endsequence
  property p_capture;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_low_read_one |=> held_one_reg && latch_one_reg == $past(count_one_reg[9:8]);
  endproperty
  a_capture: assert property (p_capture) else $error("low read did not capture high bits");

  property p_high_read_clears;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_rd && i_addr == qdx_pkg::ADDR_ONE_HIGH |=> !held_one_reg;
  endproperty
  a_high_read_clears: assert property (p_high_read_clears) else $error("high read kept latch");

  property p_high_zero_top;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_rd && (i_addr == qdx_pkg::ADDR_ONE_HIGH || i_addr == qdx_pkg::ADDR_TWO_HIGH) |=> o_rdata[7:2] == 6'h00;
  endproperty
  a_high_zero_top: assert property (p_high_zero_top) else $error("high register top bits nonzero");

  property p_high_value;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_rd && i_addr == qdx_pkg::ADDR_TWO_HIGH |=>
      o_rdata[1:0] == ($past(held_two_reg) ? $past(latch_two_reg) : $past(count_two_reg[9:8]));
  endproperty
  a_high_value: assert property (p_high_value) else $error("high register value wrong");

  property p_sel_change_no_step;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (sel_one != sel_one_prev_reg) |=> count_one_reg[7:0] == $past(count_one_reg[7:0]);
  endproperty
  a_sel_change_no_step: assert property (p_sel_change_no_step) else $error("select write stepped counter");

  property p_off_holds;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    sel_two == qdx_pkg::SEL_OFF && sel_two_prev_reg == qdx_pkg::SEL_OFF && phase_two_reg == 2'h0
      |=> count_two_reg[7:0] == $past(count_two_reg[7:0]);
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("disabled decoder counted");

  property p_prio_off;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    control_reg[1:0] == 2'h0 |-> !o_irq;
  endproperty
  a_prio_off: assert property (p_prio_off) else $error("interrupt while disabled");

  property p_step_down;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    step_one == QDX_DOWN && count_one_reg[7:0] != 8'h00 |=> count_one_reg[7:0] == $past(count_one_reg[7:0]) - 8'h01;
  endproperty
  a_step_down: assert property (p_step_down) else $error("down step wrong");

  property p_rdata_idle;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !i_rd |=> o_rdata == '0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");

  sequence s_low_read_two;
    i_rd && i_addr == qdx_pkg::ADDR_TWO_LOW;
  endsequence
  property p_capture_two;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    s_low_read_two |=> held_two_reg && latch_two_reg == $past(count_two_reg[9:8]);
  endproperty
  a_capture_two: assert property (p_capture_two) else $error("low read did not capture decoder two");

  property p_high_clears_two;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_rd && i_addr == qdx_pkg::ADDR_TWO_HIGH |=> !held_two_reg;
  endproperty
  a_high_clears_two: assert property (p_high_clears_two) else $error("high read kept decoder two latch");

  property p_high_value_one;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_rd && i_addr == qdx_pkg::ADDR_ONE_HIGH |=>
      o_rdata[1:0] == ($past(held_one_reg) ? $past(latch_one_reg) : $past(count_one_reg[9:8]));
  endproperty
  a_high_value_one: assert property (p_high_value_one) else $error("decoder one high value wrong");

  property p_wide_select;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_wr && i_addr == qdx_pkg::ADDR_CONTROL |=> wide == $past(i_wdata[qdx_pkg::CTL_WIDE_BIT]);
  endproperty
  a_wide_select: assert property (p_wide_select) else $error("width bit not taken");

  property p_wrap_up_one;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    wide && step_one == QDX_UP && count_one_reg == 10'h3FF |=> count_one_reg == 10'h000 && status_reg[0];
  endproperty
  a_wrap_up_one: assert property (p_wrap_up_one) else $error("10-bit wrap wrong");

  property p_wrap_down_two;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !wide && step_two == QDX_DOWN && count_two_reg[7:0] == 8'h00 |=> count_two_reg == 10'h0FF && status_reg[1];
  endproperty
  a_wrap_down_two: assert property (p_wrap_down_two) else $error("8-bit wrap wrong");

  property p_step_up;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    step_two == QDX_UP && count_two_reg[7:0] != 8'hFF |=> count_two_reg[7:0] == $past(count_two_reg[7:0]) + 8'h01;
  endproperty
  a_step_up: assert property (p_step_up) else $error("up step wrong");

  property p_sel_change_two;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    (sel_two != sel_two_prev_reg) |=> count_two_reg[7:0] == $past(count_two_reg[7:0]);
  endproperty
  a_sel_change_two: assert property (p_sel_change_two) else $error("select write stepped decoder two");

  property p_off_holds_one;
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    sel_one == qdx_pkg::SEL_OFF && sel_one_prev_reg == qdx_pkg::SEL_OFF |=> count_one_reg[7:0] == $past(count_one_reg[7:0]);
  endproperty
  a_off_holds_one: assert property (p_off_holds_one) else $error("disabled decoder one counted");

endmodule // qdx_decoder

// ---- verilog/qdx_pkg.sv ----
// qdx_pkg: register map, field positions and encodings of the quadrature decoder extension
// assumes a byte-wide register port with an eight-bit address
package qdx_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CNT_W = 10;
  localparam int unsigned CNT_LO_W = 8;
  localparam int unsigned HI_W = 2;
  localparam int unsigned PORT_W = 8;
  // control and count-high register offsets
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h91;
  localparam logic [ADDR_W-1:0] ADDR_ONE_HIGH = 8'h95;
  localparam logic [ADDR_W-1:0] ADDR_TWO_HIGH = 8'h97;
  // offsets of the low-count and interrupt registers
  localparam logic [ADDR_W-1:0] ADDR_ONE_LOW = 8'h94;
  localparam logic [ADDR_W-1:0] ADDR_TWO_LOW = 8'h96;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h98;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h99;
  // control fields
  localparam int unsigned CTL_SEL_TWO_HI = 7;
  localparam int unsigned CTL_SEL_TWO_LO = 6;
  localparam int unsigned CTL_WIDE_BIT = 5;
  localparam int unsigned CTL_RSVD_BIT = 4;
  localparam int unsigned CTL_SEL_ONE_HI = 3;
  localparam int unsigned CTL_SEL_ONE_LO = 2;
  localparam int unsigned CTL_PRIO_HI = 1;
  localparam int unsigned CTL_PRIO_LO = 0;
  localparam logic [DATA_W-1:0] CTL_RESET = 8'h00;
  // input select codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_LOW_PINS = 2'h2;
  localparam logic [1:0] SEL_HIGH_PINS = 2'h3;
  // port pin numbers, phase a is the higher pin of each pair
  localparam int unsigned PIN_ONE_LOW_A = 1;
  localparam int unsigned PIN_ONE_LOW_B = 0;
  localparam int unsigned PIN_ONE_HIGH_A = 5;
  localparam int unsigned PIN_ONE_HIGH_B = 4;
  localparam int unsigned PIN_TWO_LOW_A = 3;
  localparam int unsigned PIN_TWO_LOW_B = 2;
  localparam int unsigned PIN_TWO_HIGH_A = 7;
  localparam int unsigned PIN_TWO_HIGH_B = 6;
  // interrupt status bits
  localparam int unsigned IRQ_ONE_WRAP = 0;
  localparam int unsigned IRQ_TWO_WRAP = 1;
  localparam int unsigned IRQ_W = 2;
  localparam logic [1:0] PRIO_OFF = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
endpackage
